//--- rtc_serial_slave_port_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_serial_slave_port_tb
   import rtcssp_pkg::*;
;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic WR_READY = 1'b0;
   logic below = 1'b0;
   logic above = 1'b1;
   logic m_scl, m_sda, scl_en, sda_en, WR_VALID, BUS_ENABLED, ack, active, scl_o, sda_o;
   logic stretched = 1'b0;
   logic [7:0] d;
   logic [3:0] ADDR_POINTER;
   logic [RTCSSP_NREG-1:0][7:0] REG_IMAGE;
   rtcssp_wr_t WR_ENTRY;
   rtcssp_wr_t popped[$];
   logic [11:0] exp_w[3] = '{12'h811, 12'h922, 12'h033};
   int mismatches = 0;
   int n_checks = 0;
   wire scl = ~(m_scl | scl_en);
   wire sda = ~(m_sda | sda_en);

   rtcssp_core dut (.CLK(CLK), .RST(RST), .SCL_IN(scl), .SCL_OUT(scl_o), .SCL_OUT_EN(scl_en),
      .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OUT_EN(sda_en), .BELOW_POWER_FAIL_THRESHOLD(below),
      .ABOVE_SUPPLY_SWITCHOVER_THRESHOLD(above), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
      .WR_ENTRY(WR_ENTRY), .REG_IMAGE(REG_IMAGE), .ADDR_POINTER(ADDR_POINTER),
      .BUS_ENABLED(BUS_ENABLED), .BUS_ACTIVE(active));
   rtcssp_master m (.scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda));

   always #2 CLK = ~CLK;

   // bytes leaving the buffer, and whether the clock was ever stretched;
   // sampled mid-cycle so the edge that launches them cannot race the read
   always @(negedge CLK)
   begin
      if (WR_VALID && WR_READY) popped.push_back(WR_ENTRY);
      if (scl_en === 1'b1) stretched = 1'b1;
   end

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      mismatches += m.hangs;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // start plus slave byte, with the expected answer
   task automatic sel(input logic [7:0] slave, input logic exp_ack);
      m.start();
      m.wr(slave, ack);
      chk(ack, exp_ack);
   endtask

   task automatic rdchk(input logic mack, input logic [7:0] exp);
      m.rd(mack, d);
      chk(d, exp);
   endtask

   // a hung bus must not hang the run
   initial
   begin
      #300000;
      mismatches++;
      $display("ERROR %0t: run timed out", $time);
      complete_run();
   end

   initial
   begin
      repeat (8) @(posedge CLK);
      #1 RST = 1'b0;
      repeat (20) @(posedge CLK);
      for (int i = 0; i < RTCSSP_NREG; i++) chk(REG_IMAGE[i], RTCSSP_REG_RESET);
      chk(ADDR_POINTER, RTCSSP_ADDR_FIRST);
      chk({scl_o, sda_o}, 2'b00);
      chk(active, 1'b0);
      $display("test reset done");
      // stream across the wrap while the receiver stalls
      fork
         begin
            sel(8'hD0, 1'b1);
            m.wr(8'h08, ack);
            chk(ack, 1'b1);
            for (int i = 0; i < 3; i++)
            begin
               m.wr(exp_w[i][7:0], ack);
               chk(ack, 1'b1);
            end
            m.stop();
         end
         begin
            repeat (1750) @(posedge CLK);
            #1 WR_READY = 1'b1;
         end
      join
      repeat (20) @(posedge CLK);
      for (int i = 0; i < 3; i++) chk(popped[i], exp_w[i]);
      chk(REG_IMAGE[0], 8'h33);
      chk(ADDR_POINTER, 4'h1);
      chk(stretched, 1'b1);
      $display("test stream write done");
      // set pointer, repeated start, read across the wrap
      sel(8'hD0, 1'b1);
      m.wr(8'h09, ack);
      sel(8'hD1, 1'b1);
      rdchk(1'b1, 8'h22);
      rdchk(1'b0, 8'h33);
      repeat (30) @(posedge CLK);
      chk(sda_en, 1'b0);
      chk(ADDR_POINTER, 4'h0);
      m.stop();
      sel(8'hD1, 1'b1);
      rdchk(1'b0, 8'h33);
      m.stop();
      sel(8'hA0, 1'b0);
      m.stop();
      $display("test read done");
      // address beyond the map
      sel(8'hD0, 1'b1);
      m.wr(8'h0C, ack);
      m.wr(8'h44, ack);
      m.stop();
      chk(REG_IMAGE[0], 8'h44);
      chk(ADDR_POINTER, 4'h1);
      chk(active, 1'b0);
      $display("test wrap done");
      // supply fails in mid-access, then returns
      sel(8'hD0, 1'b1);
      m.wr(8'h05, ack);
      chk(active, 1'b1);
      @(posedge CLK);
      #1 below = 1'b1;
      above = 1'b0;
      repeat (12) @(posedge CLK);
      chk(BUS_ENABLED, 1'b0);
      chk(active, 1'b0);
      chk(ADDR_POINTER, 4'h0);
      m.wr(8'h55, ack);
      chk(ack, 1'b0);
      m.stop();
      sel(8'hD0, 1'b0);
      m.stop();
      chk(REG_IMAGE[5], 8'h00);
      @(posedge CLK);
      #1 below = 1'b0;
      above = 1'b1;
      for (int n = 0; n < 100 && BUS_ENABLED !== 1'b1; n++) @(posedge CLK);
      chk(BUS_ENABLED, 1'b1);
      sel(8'hD0, 1'b1);
      m.wr(8'h05, ack);
      m.wr(8'h66, ack);
      m.stop();
      chk(REG_IMAGE[5], 8'h66);
      $display("test supply done");
      complete_run();
   end
endmodule
`default_nettype wire

//--- rtcssp_buf.sv
`timescale 1ns/100ps
`default_nettype none
module rtcssp_buf
   import rtcssp_pkg::*;
#(
   parameter int W = $bits(rtcssp_wr_t),
   parameter int DEPTH = 2
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } rtcssp_buf_t;

   rtcssp_buf_t r_q;
   rtcssp_buf_t r_d;
   logic push;
   logic pop;

   if (DEPTH != 2)
   begin : g_bad_depth
      $error("rtcssp_buf: pointer wrap serves a depth of two only");
   end

   assign in_ready = (r_q.cnt != CNT_FULL); // count is one bit wider than the pointers
   assign out_valid = (r_q.cnt != '0);
   assign out_data = r_q.mem[r_q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage and pointers; full stalls the source, never drops
   always_comb
   begin
      r_d = r_q;
      if (push)
      begin
         r_d.mem[r_q.wp] = in_data;
         r_d.wp = r_q.wp + 1'b1;
      end
      if (pop)
         r_d.rp = r_q.rp + 1'b1;
      if (push && !pop)
         r_d.cnt = r_q.cnt + 1'b1;
      else if (pop && !push)
         r_d.cnt = r_q.cnt - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         r_q <= '0;
      else
         r_q <= r_d;
   end

endmodule
`default_nettype wire

//--- rtcssp_chk.sv
`timescale 1ns/100ps
`default_nettype none
module rtcssp_chk
   import rtcssp_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // bus
   input wire logic SCL_IN,
   input wire logic SCL_OUT_EN,
   input wire logic SDA_OUT_EN,
   // supply
   input wire logic BELOW_POWER_FAIL_THRESHOLD,
   // write stream and status
   input wire logic WR_VALID,
   input wire logic WR_READY,
   input wire rtcssp_wr_t WR_ENTRY,
   input wire logic [RTCSSP_NREG-1:0][7:0] REG_IMAGE,
   input wire logic [3:0] ADDR_POINTER,
   input wire logic BUS_ENABLED
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // a pulled-low data line lasts well past the synchroniser lag
   sequence s_pull_low;
      SDA_OUT_EN[*8];
   endsequence
   // supply failure seen long enough to pass the synchroniser
   sequence s_failed;
      BELOW_POWER_FAIL_THRESHOLD[*8];
   endsequence

   property p_pull_hold;
      $rose(SDA_OUT_EN) |-> s_pull_low;
   endproperty
   a_pull_hold: assert property (p_pull_hold) else $error("data pull dropped early");
   property p_change_low;
      $changed(SDA_OUT_EN) |-> !SCL_IN;
   endproperty
   a_change_low: assert property (p_change_low) else $error("data moved with clock high");
   property p_ack_enabled;
      $rose(SDA_OUT_EN) |-> BUS_ENABLED;
   endproperty
   a_ack_enabled: assert property (p_ack_enabled) else $error("drive while disabled");
   property p_fail_pointer;
      s_failed |-> ADDR_POINTER == RTCSSP_ADDR_FIRST;
   endproperty
   a_fail_pointer: assert property (p_fail_pointer) else $error("pointer kept in fail");
   property p_fail_frozen;
      s_failed |=> $stable(REG_IMAGE) && !$rose(WR_VALID) && !SDA_OUT_EN;
   endproperty
   a_fail_frozen: assert property (p_fail_frozen) else $error("activity in fail");
   property p_ptr_range;
      ADDR_POINTER <= RTCSSP_ADDR_LAST && (!WR_VALID || WR_ENTRY.addr <= RTCSSP_ADDR_LAST);
   endproperty
   a_ptr_range: assert property (p_ptr_range) else $error("address beyond map");
   property p_write_stream;
      $changed(REG_IMAGE) |-> ##[0:2] WR_VALID;
   endproperty
   a_write_stream: assert property (p_write_stream) else $error("write not forwarded");
   property p_hold_entry;
      WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_ENTRY);
   endproperty
   a_hold_entry: assert property (p_hold_entry) else $error("entry lost on stall");
   property p_stretch_start;
      $rose(SCL_OUT_EN) |-> WR_VALID && !SCL_IN;
   endproperty
   a_stretch_start: assert property (p_stretch_start) else $error("bad stretch");
   property p_stretch_end;
      SCL_OUT_EN && WR_VALID && WR_READY |-> ##[1:4] !SCL_OUT_EN;
   endproperty
   a_stretch_end: assert property (p_stretch_end) else $error("stretch not released");
endmodule

bind rtcssp_core rtcssp_chk chk (.CLK(CLK), .RST(RST), .SCL_IN(SCL_IN),
   .SCL_OUT_EN(SCL_OUT_EN), .SDA_OUT_EN(SDA_OUT_EN),
   .BELOW_POWER_FAIL_THRESHOLD(BELOW_POWER_FAIL_THRESHOLD), .WR_VALID(WR_VALID),
   .WR_READY(WR_READY), .WR_ENTRY(WR_ENTRY), .REG_IMAGE(REG_IMAGE),
   .ADDR_POINTER(ADDR_POINTER), .BUS_ENABLED(BUS_ENABLED));
`default_nettype wire

//--- rtcssp_core.sv
`timescale 1ns/100ps
`default_nettype none
module rtcssp_core
   import rtcssp_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // two-wire bus, open drain: output enable high pulls the line low
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OUT_EN,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OUT_EN,
   // supply monitor levels
   input wire logic BELOW_POWER_FAIL_THRESHOLD,
   input wire logic ABOVE_SUPPLY_SWITCHOVER_THRESHOLD,
   // written bytes towards the timekeeping core
   output logic WR_VALID,
   input wire logic WR_READY,
   output rtcssp_wr_t WR_ENTRY,
   // register image and status
   output logic [RTCSSP_NREG-1:0][7:0] REG_IMAGE,
   output logic [3:0] ADDR_POINTER,
   output logic BUS_ENABLED,
   output logic BUS_ACTIVE
);

   typedef struct packed {
      rtcssp_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [3:0] ptr;
      logic rd;
      logic first;
      logic mack;
      logic sda_oe;
      logic scl_oe;
      logic bus_en;
      logic scl_prev;
      logic sda_prev;
      logic [RTCSSP_NREG-1:0][7:0] regs;
   } rtcssp_core_t;

   rtcssp_core_t r_q;
   rtcssp_core_t r_d;

   logic [RTCSSP_IN_W-1:0] raw_in;
   logic [RTCSSP_IN_W-1:0] lvl;
   logic scl;
   logic sda;
   logic pfail;
   logic main_ok;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic buf_in_valid;
   logic buf_in_ready;
   rtcssp_wr_t buf_in_data;
   logic [3:0] ptr_next;

   if (RTCSSP_NREG != 32'(RTCSSP_ADDR_LAST) + 1)
   begin : g_bad_map
      $error("rtcssp_core: register count and last address disagree");
   end

   // pins come from outside this clock: three flops, agreement filter
   assign raw_in[RTCSSP_IN_SCL] = SCL_IN;
   assign raw_in[RTCSSP_IN_SDA] = SDA_IN;
   assign raw_in[RTCSSP_IN_PFAIL] = BELOW_POWER_FAIL_THRESHOLD;
   assign raw_in[RTCSSP_IN_MAIN] = ABOVE_SUPPLY_SWITCHOVER_THRESHOLD;

   rtcssp_sync #(
      .W(RTCSSP_IN_W),
      .RESET_VAL(RTCSSP_IN_RESET)
   ) u_sync (
      .clk(CLK),
      .rst(RST),
      .async_in(raw_in),
      .level_out(lvl)
   );

   assign scl = lvl[RTCSSP_IN_SCL];
   assign sda = lvl[RTCSSP_IN_SDA];
   assign pfail = lvl[RTCSSP_IN_PFAIL];
   assign main_ok = lvl[RTCSSP_IN_MAIN];

   // bus conditions from filtered levels; data moving under a high
   // clock is never taken as data
   assign scl_rise = scl && !r_q.scl_prev;
   assign scl_fall = !scl && r_q.scl_prev;
   assign start_cond = scl && r_q.scl_prev && r_q.sda_prev && !sda;
   assign stop_cond = scl && r_q.scl_prev && !r_q.sda_prev && sda;

   // next pointer with wrap past the last register
   assign ptr_next = (r_q.ptr >= RTCSSP_ADDR_LAST) ? RTCSSP_ADDR_FIRST
      : r_q.ptr + RTCSSP_CNT_ONE;

   // written data goes to the core through a two-entry buffer
   assign buf_in_valid = (r_q.st == RTCSSP_COMMIT) && !r_q.first;
   assign buf_in_data = {r_q.ptr, r_q.sh};

   rtcssp_buf #(
      .W($bits(rtcssp_wr_t)),
      .DEPTH(2)
   ) u_buf (
      .clk(CLK),
      .rst(RST),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(WR_VALID),
      .out_ready(WR_READY),
      .out_data(WR_ENTRY)
   );

   // protocol engine; register file sits in the same state word
   always_comb
   begin
      r_d = r_q;
      r_d.scl_prev = scl;
      r_d.sda_prev = sda;
      // enable falls at once on fail, returns only on main supply
      if (pfail)
         r_d.bus_en = 1'b0;
      else if (main_ok)
         r_d.bus_en = 1'b1;

      if (pfail || !r_q.bus_en)
      begin
         // abort, clear counter, release both lines
         r_d.st = RTCSSP_IDLE;
         r_d.ptr = RTCSSP_ADDR_FIRST;
         r_d.cnt = RTCSSP_CNT_ZERO;
         r_d.sda_oe = 1'b0;
         r_d.scl_oe = 1'b0;
      end
      else if (start_cond)
      begin
         // a start, repeated or not, always listens for the slave byte
         r_d.st = RTCSSP_DEVADR;
         r_d.cnt = RTCSSP_CNT_ZERO;
         r_d.sda_oe = 1'b0;
         r_d.scl_oe = 1'b0;
      end
      else if (stop_cond)
      begin
         r_d.st = RTCSSP_IDLE;
         r_d.sda_oe = 1'b0;
         r_d.scl_oe = 1'b0;
      end
      else
      begin
         case (r_q.st)
            RTCSSP_IDLE:
            begin
               r_d.sda_oe = 1'b0;
            end
            RTCSSP_DEVADR,
            RTCSSP_RX:
            begin
               // sample on the rising clock, act on the falling one
               if (scl_rise && r_q.cnt != RTCSSP_BITS_PER_BYTE)
               begin
                  r_d.sh = {r_q.sh[6:0], sda};
                  r_d.cnt = r_q.cnt + RTCSSP_CNT_ONE;
               end
               else if (scl_fall && r_q.cnt == RTCSSP_BITS_PER_BYTE)
               begin
                  if (r_q.st == RTCSSP_RX)
                     r_d.st = RTCSSP_COMMIT;
                  else if (r_q.sh[7:1] == RTCSSP_SLAVE_ID)
                  begin
                     r_d.rd = r_q.sh[0];
                     r_d.first = !r_q.sh[0];
                     r_d.st = RTCSSP_ACK;
                     r_d.sda_oe = 1'b1;
                  end
                  else
                     r_d.st = RTCSSP_WAIT;
               end
            end
            RTCSSP_COMMIT:
            begin
               if (r_q.first)
               begin
                  // address byte: load pointer, wrap values past the end
                  r_d.ptr = (r_q.sh > {4'h0, RTCSSP_ADDR_LAST}) ? RTCSSP_ADDR_FIRST
                     : r_q.sh[3:0];
                  r_d.first = 1'b0;
                  r_d.st = RTCSSP_ACK;
                  r_d.sda_oe = 1'b1;
                  r_d.scl_oe = 1'b0;
               end
               else if (buf_in_ready)
               begin
                  r_d.regs[r_q.ptr] = r_q.sh;
                  r_d.ptr = ptr_next;
                  r_d.st = RTCSSP_ACK;
                  r_d.sda_oe = 1'b1;
                  // a stretched clock is let go one cycle later, in the ack state
               end
               else
                  // buffer full: hold the clock low rather than lose a byte
                  r_d.scl_oe = 1'b1;
            end
            RTCSSP_ACK:
            begin
               // stretch ends after the pull is down, so data never moves under a high clock
               r_d.scl_oe = 1'b0;
               // low held until the acknowledge pulse has fallen again
               if (scl_fall)
               begin
                  r_d.cnt = RTCSSP_CNT_ZERO;
                  if (r_q.rd)
                  begin
                     // read begins at the held pointer
                     r_d.st = RTCSSP_TX;
                     r_d.sh = r_q.regs[r_q.ptr];
                     r_d.sda_oe = !r_q.regs[r_q.ptr][7];
                  end
                  else
                  begin
                     r_d.st = RTCSSP_RX;
                     r_d.sda_oe = 1'b0;
                  end
               end
            end
            RTCSSP_TX:
            begin
               // bits change only after a falling clock
               if (scl_fall)
               begin
                  r_d.cnt = r_q.cnt + RTCSSP_CNT_ONE;
                  if (r_q.cnt == RTCSSP_BITS_PER_BYTE - RTCSSP_CNT_ONE)
                  begin
                     r_d.st = RTCSSP_MACK;
                     r_d.sda_oe = 1'b0;
                     r_d.mack = 1'b0;
                  end
                  else
                  begin
                     r_d.sh = {r_q.sh[6:0], 1'b0};
                     r_d.sda_oe = !r_q.sh[6];
                  end
               end
            end
            RTCSSP_MACK:
            begin
               if (scl_rise)
                  r_d.mack = !sda;
               else if (scl_fall)
               begin
                  if (r_q.mack)
                  begin
                     // acknowledged: advance and send the next byte
                     r_d.ptr = ptr_next;
                     r_d.sh = r_q.regs[ptr_next];
                     r_d.sda_oe = !r_q.regs[ptr_next][7];
                     r_d.cnt = RTCSSP_CNT_ZERO;
                     r_d.st = RTCSSP_TX;
                  end
                  else
                  begin
                     // end of read: line left high, wait for stop
                     r_d.sda_oe = 1'b0;
                     r_d.st = RTCSSP_WAIT;
                  end
               end
            end
            RTCSSP_WAIT:
            begin
               r_d.sda_oe = 1'b0;
            end
            default:
            begin
               r_d.st = RTCSSP_IDLE;
               r_d.sda_oe = 1'b0;
               r_d.scl_oe = 1'b0;
            end
         endcase
      end
   end

   // state register; bus disabled until the supply is seen good
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         r_q.st <= RTCSSP_IDLE;
         r_q.cnt <= RTCSSP_CNT_ZERO;
         r_q.sh <= RTCSSP_REG_RESET;
         r_q.ptr <= RTCSSP_ADDR_FIRST;
         r_q.rd <= 1'b0;
         r_q.first <= 1'b0;
         r_q.mack <= 1'b0;
         r_q.sda_oe <= 1'b0;
         r_q.scl_oe <= 1'b0;
         r_q.bus_en <= 1'b0;
         r_q.scl_prev <= 1'b1;
         r_q.sda_prev <= 1'b1;
         r_q.regs <= {RTCSSP_NREG{RTCSSP_REG_RESET}};
      end
      else
         r_q <= r_d;
   end

   // open-drain pins only ever pull low
   assign SCL_OUT = 1'b0;
   assign SDA_OUT = 1'b0;
   assign SCL_OUT_EN = r_q.scl_oe;
   assign SDA_OUT_EN = r_q.sda_oe;

   // register image, pointer and enable straight from flops; BUS_ACTIVE decoded from the state
   assign REG_IMAGE = r_q.regs;
   assign ADDR_POINTER = r_q.ptr;
   assign BUS_ENABLED = r_q.bus_en;
   assign BUS_ACTIVE = (r_q.st != RTCSSP_IDLE);

endmodule
`default_nettype wire

//--- rtcssp_master.sv
`timescale 1ns/100ps
`default_nettype none
module rtcssp_master
   import rtcssp_pkg::*;
(
   // wire levels seen by the master
   input wire logic scl,
   input wire logic sda,
   // open-drain pulls, high pulls the line low
   output logic scl_pull,
   output logic sda_pull
);
   localparam realtime Q = 31.25; // quarter of a 125 ns bus clock
   int hangs = 0;

   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   // one bit slot; data only moves while the clock is low
   task automatic slot(input logic b, output logic r);
      int n;
      #Q sda_pull = ~b;
      #Q scl_pull = 1'b0;
      n = 0;
      // a stretched clock is honoured, but never forever
      while (scl !== 1'b1 && n < 20000)
      begin
         #1;
         n++;
      end
      if (n == 20000) hangs++;
      #Q r = sda;
      #Q scl_pull = 1'b1;
   endtask

   // start from idle, or repeated start from a low clock
   task automatic start();
      #Q sda_pull = 1'b0;
      #Q scl_pull = 1'b0;
      #(2*Q) sda_pull = 1'b1;
      #(2*Q) scl_pull = 1'b1;
   endtask

   // stop, then leave the bus free a while
   task automatic stop();
      #Q sda_pull = 1'b1;
      #Q scl_pull = 1'b0;
      #(2*Q) sda_pull = 1'b0;
      #(4*Q);
   endtask

   // byte out, msb first, ninth slot left to the slave
   task automatic wr(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) slot(b[i], r);
      slot(1'b1, r);
      ack = ~r;
   endtask

   // byte in, then our own acknowledge or its absence
   task automatic rd(input logic mack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) slot(1'b1, d[i]);
      slot(~mack, r);
   endtask
endmodule
`default_nettype wire

//--- rtcssp_pkg.sv
package rtcssp_pkg;

   // slave identity: D0h on the wire with the direction bit cleared
   localparam logic [6:0] RTCSSP_SLAVE_ID = 7'h68;

   // register map, one byte each
   localparam int RTCSSP_NREG = 10;
   localparam logic [3:0] RTCSSP_ADDR_SECONDS = 4'h0;
   localparam logic [3:0] RTCSSP_ADDR_MINUTES = 4'h1;
   localparam logic [3:0] RTCSSP_ADDR_CENTURY_HOURS = 4'h2;
   localparam logic [3:0] RTCSSP_ADDR_WEEKDAY = 4'h3;
   localparam logic [3:0] RTCSSP_ADDR_MONTH_DAY = 4'h4;
   localparam logic [3:0] RTCSSP_ADDR_MONTH = 4'h5;
   localparam logic [3:0] RTCSSP_ADDR_YEAR = 4'h6;
   localparam logic [3:0] RTCSSP_ADDR_TRIM_AND_CONTROL = 4'h7;
   localparam logic [3:0] RTCSSP_ADDR_SOUND_SETTINGS = 4'h8;
   localparam logic [3:0] RTCSSP_ADDR_SECONDARY_CONTROL = 4'h9;
   localparam logic [3:0] RTCSSP_ADDR_FIRST = RTCSSP_ADDR_SECONDS;
   localparam logic [3:0] RTCSSP_ADDR_LAST = RTCSSP_ADDR_SECONDARY_CONTROL;
   localparam logic [7:0] RTCSSP_REG_RESET = 8'h00;

   // byte framing: eight data bits, then the acknowledge slot
   localparam logic [3:0] RTCSSP_BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] RTCSSP_CNT_ZERO = 4'h0;
   localparam logic [3:0] RTCSSP_CNT_ONE = 4'h1;

   // positions of the inputs inside the synchroniser vector
   localparam int RTCSSP_IN_SCL = 0;
   localparam int RTCSSP_IN_SDA = 1;
   localparam int RTCSSP_IN_PFAIL = 2;
   localparam int RTCSSP_IN_MAIN = 3;
   localparam int RTCSSP_IN_W = 4;
   // bus lines idle high, supply flags idle as failed / on backup
   localparam logic [RTCSSP_IN_W-1:0] RTCSSP_IN_RESET = 4'h7;

   // protocol states
   typedef enum {
      RTCSSP_IDLE,
      RTCSSP_DEVADR,
      RTCSSP_RX,
      RTCSSP_COMMIT,
      RTCSSP_ACK,
      RTCSSP_TX,
      RTCSSP_MACK,
      RTCSSP_WAIT
   } rtcssp_state_t;

   // one written byte handed to the timekeeping core
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] data;
   } rtcssp_wr_t;

endpackage

//--- rtcssp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module rtcssp_sync
   import rtcssp_pkg::*;
#(
   parameter int W = RTCSSP_IN_W,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // raw and filtered levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] level_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } rtcssp_sync_t;

   rtcssp_sync_t r_q;
   rtcssp_sync_t r_d;
   logic [W-1:0] lvl_d;

   if (W < 1)
   begin : g_bad_width
      $error("rtcssp_sync: width must be at least one");
   end

   // per-bit agreement filter; a level moves only when s2 and s3 agree
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      assign lvl_d[i] = (r_q.s2[i] == r_q.s3[i]) ? r_q.s3[i] : r_q.lvl[i];
   end

   // s1 feeds only s2, so a metastable s1 never reaches the filter
   always_comb
   begin
      r_d = r_q;
      r_d.s1 = async_in;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
      r_d.lvl = lvl_d;
   end

   // all stages start at the idle levels
   always_ff @(posedge clk)
   begin
      if (rst)
         r_q <= {4{RESET_VAL}};
      else
         r_q <= r_d;
   end

   assign level_out = r_q.lvl;

endmodule
`default_nettype wire
